/* testbench/host_serial_model.sv */
/*
 * Host-side reader for the slave serial link: makes the serial clock and chip select.
 * Assumes sdata_i watches the serial data pin and inv_i the clock invert strap.
 */
`timescale 1ns/1ps
module host_serial_model (
    input wire logic sdata_i, // Serial data from block
    input wire logic inv_i, // Clock invert strap
    output logic sclk_o, // Host serial clock
    output logic cs_n_o, // Chip select, active low
    output logic daisy_o // Daisy chain level
);
    // ****************************************
    // Frame reads
    // ****************************************
    // Idle levels before any frame
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        daisy_o = 1'b0;
    end
    // Clock toggles only inside a frame, parked at its inactive level between
    task automatic read(input int n, input logic dz, input logic last, output logic [31:0] bits);
        bits = 32'h0;
        daisy_o = dz;
        sclk_o = inv_i;
        #100 cs_n_o = 1'b0;
        #400;
        for (int i = 0; i < n; i++) begin
            bits = {bits[30:0], sdata_i}; // Sample just before the active edge
            sclk_o = ~inv_i;
            #160 sclk_o = inv_i;
            #160;
        end
        if (last) cs_n_o = 1'b1;
    endtask
    // Close a frame left open
    task automatic stop();
        cs_n_o = 1'b1;
    endtask
endmodule // host_serial_model

/* testbench/test_adc_serial_result_port.sv */
/*
 * Self-checking bench: registers, parallel pins, master and slave shift-out.
 * Assumes the host model drives the slave clock and chip select.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module test_adc_serial_result_port;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [3:0] sel_i = 4'hf;
    logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
    logic [13:0] result_i = 14'h0;
    logic conv_start_i = 1'b0, conv_done_i = 1'b0, typ = 1'b0, fmt = 1'b0;
    logic src = 1'b0, pol = 1'b0, inv = 1'b0, read_timing = 1'b0;
    logic [3:0] wsel = 4'hf;
    logic [1:0] div = 2'b00;
    logic [7:0] d_in_i, d_out_o, d_oe_o;
    logic frame_marker_o, incomplete_read_flag_o, host_clk, host_cs_n, daisy;
    int fail_count = 0;
    int comparisons = 0;
    // Strap pins; slave borrows bit 7 and bit 5 for host clock and daisy level
    assign d_in_i = {src & host_clk, 1'b0, src ? daisy : read_timing, inv, pol, src, div};
    always #20 clk_i = ~clk_i;
    adc_serial_result_port adc_serial_result_port_inst (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .result_i(result_i),
        .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
        .interface_type_select_i(typ), .number_format_select_i(fmt), .cs_n_i(host_cs_n),
        .d_in_i(d_in_i), .d_out_o(d_out_o), .d_oe_o(d_oe_o), .frame_marker_o(frame_marker_o),
        .incomplete_read_flag_o(incomplete_read_flag_o));
    host_serial_model host_serial_model_inst (.sdata_i(d_out_o[6]), .inv_i(inv),
        .sclk_o(host_clk), .cs_n_o(host_cs_n), .daisy_o(daisy));
    // ****************************************
    // Helpers
    // ****************************************
    // Expected 16-bit frame: MSB first, MSB flipped unless straight binary, two zeros
    function automatic logic [15:0] frame_of(input logic [13:0] r, input logic f);
        return {f ? r[13] : ~r[13], r[12:0], 2'b00};
    endfunction
    // Classic single cycle; held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= wsel;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (n == 50) fail_count++;
        q = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask
    // One-cycle conversion done or start pulse
    task automatic conv(input logic [13:0] r, input logic done);
        @(posedge clk_i);
        result_i <= r; conv_done_i <= done; conv_start_i <= ~done;
        @(posedge clk_i);
        conv_done_i <= 1'b0; conv_start_i <= 1'b0;
    endtask
    // Bounded wait for a level on the generated clock pin
    task automatic wait_d7(input logic v, inout int c);
        int n;
        for (n = 0; n < 600 && d_out_o[7] !== v; n++) begin
            @(posedge clk_i);
            c++;
        end
        if (n == 600) fail_count++;
    endtask
    // Capture a master frame on active edges, measuring one bit period
    task automatic master(output logic [15:0] bits, output int per);
        int c;
        c = 0; per = 0; bits = 16'h0;
        for (int i = 0; i < 16; i++) begin
            wait_d7(inv, c);
            wait_d7(~inv, c);
            bits = {bits[14:0], d_out_o[6]};
            `CHK(frame_marker_o, ~pol)
            if (i == 0) c = 0;
            if (i == 1) per = c;
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #1600000;
        fail_count++;
        results();
    end
    initial begin
        logic [31:0] rd, bits;
        logic [15:0] fb;
        logic [13:0] a;
        int per, h, n;
        void'($urandom(19));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h0, 32'h0, rd);
        `CHK(rd, 32'h0804_0201)
        wb(1'b1, 4'h0, 32'h0804_0202, rd);
        wb(1'b0, 4'h0, 32'h0, rd);
        `CHK(rd, 32'h0804_0202)
        wb(1'b0, 4'hc, 32'h0, rd);
        `CHK(rd, 32'h0)
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            a = 14'($urandom);
            conv(a, 1'b1);
            repeat (2) @(posedge clk_i);
            `CHK(d_out_o, a[7:0])
            `CHK(d_oe_o, 8'hff)
        end
        $display("test parallel done");
        typ <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_i);
            {pol, inv, read_timing} <= 3'(k);
            fmt <= 1'($urandom);
            div <= 2'($urandom);
            repeat (8) @(posedge clk_i);
            a = 14'($urandom);
            conv(a, 1'b1);
            if (read_timing) conv(~a, 1'b0);
            h = (read_timing || div == 2'd0) ? 2 : (1 << div);
            master(fb, per);
            `CHK(fb, frame_of(a, fmt))
            `CHK(per, 4 * h)
            `CHK(d_oe_o, 8'hc0)
            repeat (40) @(posedge clk_i);
            `CHK(frame_marker_o, pol)
        end
        wb(1'b0, 4'h4, 32'h0, rd);
        `CHK(rd[1:0], 2'b11)
        $display("test master done");
        src <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            inv <= k[0];
            fmt <= 1'($urandom);
            repeat (8) @(posedge clk_i);
            a = 14'($urandom);
            conv(a, 1'b1);
            host_serial_model_inst.read(20, k[1], 1'b1, bits);
            `CHK(bits[19:0], {frame_of(a, fmt), {4{k[1]}}})
            `CHK(d_oe_o, 8'h40)
        end
        $display("test slave done");
        a = 14'($urandom);
        conv(a, 1'b1);
        host_serial_model_inst.read(4, 1'b0, 1'b0, bits);
        conv(~a, 1'b1);
        for (n = 0; n < 10 && incomplete_read_flag_o !== 1'b1; n++) @(posedge clk_i);
        `CHK(n < 10, 1'b1)
        host_serial_model_inst.stop();
        wb(1'b0, 4'h4, 32'h0, rd);
        `CHK(rd[15:8], 8'h01)
        // Result register holds the last completed conversion
        wb(1'b0, 4'h8, 32'h0, rd);
        `CHK(rd, {18'h0, ~a})
        // Only the enabled byte lane of the divide table may change
        wsel = 4'h2;
        wb(1'b1, 4'h0, 32'hffff_ffff, rd);
        wsel = 4'hf;
        wb(1'b0, 4'h0, 32'h0, rd);
        `CHK(rd, 32'h0804_ff02)
        $display("test abort done");
        results();
    end
endmodule // test_adc_serial_result_port

/* verilog/adc_serial_result_port.sv */
/*
 * Pin-strapped result port of a sampling converter: parallel low byte or
 * serial master/slave shift-out, with Wishbone access to a small register set.
 * Assumes the converter core gives conv_start_i/conv_done_i pulses on clk_i.
 */
// Decided for this implementation: the address map and the Wishbone interface to the registers.
// What this block does
// - Parallel mode: pins 0,1 carry result bits 0,1
// - Master read-after-convert: divide pins slow clock
// - Other serial modes: divide pins high impedance
// - Source select low: master, drive clock out
// - Source select high: slave, host clock gated
// - Frame marker polarity follows polarity select
// - Edge invert picks active edge, both clocks
// - Read timing low: shift current result after
// - Read timing high: shift previous during conversion
// - Daisy input reappears after sixteen clock periods
// - Result shifted MSB first in chosen format
// - Master data stable at both clock edges
// - Slave data updates on selected host edge
// - Serial clock pin direction follows source select
// - Parallel mode: serial pins carry bits 2-7
// - Type select low parallel, high serial
// - Format high binary, low inverts MSB
// - Frame marker active while master data valid
// - Unfinished slave read lost, error pulse
`timescale 1ns/1ps
`include "serial_port_defines.svh"

module adc_serial_result_port #(
    parameter int RES_W = `RESULT_BITS,
    parameter int FRAME_W = `FRAME_BITS
) (
    input wire logic clk_i, // 25 MHz clock
    input wire logic rst_i, // Synchronous reset
    input wire logic [3:0] adr_i, // Wishbone byte address
    input wire logic [31:0] dat_i, // Wishbone write data
    output logic [31:0] dat_o, // Wishbone read data
    input wire logic [3:0] sel_i, // Wishbone byte enables
    input wire logic we_i, // Wishbone write
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    output logic ack_o, // Wishbone acknowledge
    input wire logic [RES_W-1:0] result_i, // Converter result
    input wire logic conv_start_i, // Conversion begins
    input wire logic conv_done_i, // Conversion complete
    input wire logic interface_type_select_i, // High serial
    input wire logic number_format_select_i, // High straight binary
    input wire logic cs_n_i, // Slave chip select
    input wire logic [7:0] d_in_i, // Data bus pins in
    output logic [7:0] d_out_o, // Data bus pins out
    output logic [7:0] d_oe_o, // Data bus enables
    output logic frame_marker_o, // Master frame marker
    output logic incomplete_read_flag_o // Read error pulse
);
    import serial_port_pkg::*;

    if (FRAME_W <= RES_W || FRAME_W > 32 || RES_W < 8) begin : g_bad
        $error("adc_serial_result_port: unsupported widths");
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [`PIN_COUNT-1:0] raw;
    logic [`PIN_COUNT-1:0] s1;
    logic [`PIN_COUNT-1:0] s2;
    logic [`PIN_COUNT-1:0] s3;
    logic [`PIN_COUNT-1:0] filt;
    assign raw = {cs_n_i, number_format_select_i, interface_type_select_i, d_in_i};

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= 11'h400;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < `PIN_COUNT; i++) begin
                if (s2[i] == s3[i]) begin
                    filt[i] <= s3[i];
                end
            end
        end
    end

    // Strap decode; pin 5 is read timing in master, daisy input in slave
    logic serial, master, slave, inv, pol, read_timing, fmt, sclk_in, csn;
    logic [1:0] divsel;
    assign serial = filt[`PIN_SER];
    assign slave = serial & filt[2];
    assign master = serial & ~filt[2];
    assign pol = filt[3];
    assign inv = filt[4];
    assign read_timing = filt[5];
    assign sclk_in = filt[7];
    assign fmt = filt[`PIN_FMT];
    assign csn = filt[`PIN_CSN];
    assign divsel = (master && !read_timing) ? filt[1:0] : 2'b00;

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] divide;
    logic [7:0] err_count;
    logic [RES_W-1:0] stored;
    port_state_e state;
    logic [31:0] rd_word;

    // Read mux; unmapped offsets answer zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (adr_i)
            `OFS_DIVIDE: rd_word = divide;
            `OFS_STATUS: rd_word = {16'h0000, err_count, 4'h0, state == ST_SLAVE,
                state == ST_MASTER, master, serial};
            `OFS_RESULT: rd_word = {{(32-RES_W){1'b0}}, stored};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // One wait state: ack the cycle after the request appears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            dat_o <= rd_word;
        end
    end

    // Writes land on the acknowledging edge, per byte lane
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divide <= `DIVIDE_RESET;
        end else if (cyc_i && stb_i && ack_o && we_i && adr_i == `OFS_DIVIDE) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_i[b]) begin
                    divide[b*8 +: 8] <= dat_i[b*8 +: 8];
                end
            end
        end
    end

    // Result store, refreshed at each conversion end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stored <= '0;
        end else if (conv_done_i) begin
            stored <= result_i;
        end
    end

    // ****************************************
    // Shift engine
    // ****************************************
    logic [FRAME_W-1:0] shreg;
    logic [5:0] bitcnt;
    logic [1:0] phase;
    logic [7:0] halfcnt;
    logic [7:0] halflen;
    logic sclk_prev, csn_prev, act_edge, cs_fall, rd_open, rd_fail;

    // Zero in the table would stall the divider, so treat it as one
    assign halflen = (divide[divsel*8 +: 8] == 8'h00) ? 8'h01 : divide[divsel*8 +: 8];
    assign act_edge = inv ? (sclk_prev & ~sclk_in) : (~sclk_prev & sclk_in);
    assign cs_fall = csn_prev & ~csn;
    assign rd_open = (state == ST_SLAVE) && (bitcnt < 6'(FRAME_W));
    assign rd_fail = rd_open & conv_done_i;

    // MSB first, MSB inverted for twos complement, padded to the frame
    function automatic logic [FRAME_W-1:0] frame_of(input logic [RES_W-1:0] r, input logic f);
        frame_of = {{f ? r[RES_W-1] : ~r[RES_W-1], r[RES_W-2:0]},
            {(FRAME_W-RES_W){1'b0}}};
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_prev <= 1'b0;
            csn_prev <= 1'b1;
        end else begin
            sclk_prev <= sclk_in;
            csn_prev <= csn;
        end
    end

    // Master: four phases per bit, clock high in phases 1 and 2; data moves
    // only between phase 3 and 0, away from both clock edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            shreg <= '0;
            bitcnt <= 6'h00;
            phase <= 2'h0;
            halfcnt <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    phase <= 2'h0;
                    halfcnt <= 8'h00;
                    bitcnt <= 6'h00;
                    if (master && !read_timing && conv_done_i) begin
                        state <= ST_MASTER;
                        shreg <= frame_of(result_i, fmt);
                    end else if (master && read_timing && conv_start_i) begin
                        state <= ST_MASTER;
                        shreg <= frame_of(stored, fmt);
                    end else if (slave && cs_fall) begin
                        state <= ST_SLAVE;
                        shreg <= frame_of(stored, fmt);
                    end
                end
                ST_MASTER: begin
                    if (halfcnt + 8'h01 >= halflen) begin
                        halfcnt <= 8'h00;
                        phase <= phase + 2'h1;
                        if (phase == 2'h3) begin
                            shreg <= {shreg[FRAME_W-2:0], 1'b0};
                            bitcnt <= bitcnt + 6'h01;
                            if (bitcnt == 6'(FRAME_W - 1)) begin
                                state <= ST_IDLE;
                            end
                        end
                    end else begin
                        halfcnt <= halfcnt + 8'h01;
                    end
                    if (!master) begin
                        state <= ST_IDLE;
                    end
                end
                ST_SLAVE: begin
                    if (csn || !slave || rd_fail) begin
                        state <= ST_IDLE;
                    end else if (act_edge) begin
                        // Pin 5 carries the daisy level in slave mode
                        shreg <= {shreg[FRAME_W-2:0], read_timing};
                        if (bitcnt < 6'(FRAME_W)) begin
                            bitcnt <= bitcnt + 6'h01;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Pin drivers, all registered
    // ****************************************
    logic sclk_gen;
    logic [7:0] next_d_out;
    logic [7:0] next_d_oe;
    assign sclk_gen = (state == ST_MASTER) && (phase == 2'h1 || phase == 2'h2);

    // Serial mode leaves unused pins undriven so they act as straps
    always_comb begin
        if (serial) begin
            next_d_out = {sclk_gen ^ inv, shreg[FRAME_W-1], 6'h00};
            next_d_oe = {master, 1'b1, 6'h00};
        end else begin
            next_d_out = stored[7:0];
            next_d_oe = 8'hff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d_out_o <= 8'h00;
            d_oe_o <= 8'h00;
            frame_marker_o <= 1'b0;
            incomplete_read_flag_o <= 1'b0;
        end else begin
            d_out_o <= next_d_out;
            d_oe_o <= next_d_oe;
            frame_marker_o <= ((state == ST_MASTER) && master) ^ pol;
            incomplete_read_flag_o <= rd_fail;
        end
    end

    // Error count for software; saturates rather than wraps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_count <= 8'h00;
        end else if (rd_fail && err_count != 8'hff) begin
            err_count <= err_count + 8'h01;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence clk_moves;
        state == ST_MASTER && !$stable(sclk_gen);
    endsequence
    sequence err_pulse;
        incomplete_read_flag_o ##1 !incomplete_read_flag_o;
    endsequence

    a_par_low_bits: assert property (!serial |=> d_out_o[1:0] == $past(stored[1:0]))
        else $error("parallel low bits wrong");
    a_par_mid_bits: assert property (!serial |=> d_out_o[7:2] == $past(stored[7:2]))
        else $error("parallel bits 2-7 wrong");
    a_div_pins_off: assert property (serial |=> d_oe_o[1:0] == 2'b00)
        else $error("divide pins driven");
    a_clk_pin_dir: assert property (serial |=> d_oe_o[7] == $past(master))
        else $error("clock pin direction wrong");
    a_frame_level: assert property (master && state == ST_MASTER |=> frame_marker_o != $past(pol))
        else $error("frame marker level wrong");
    a_rac_start: assert property (state == ST_IDLE && master && !read_timing && conv_done_i
        |=> state == ST_MASTER && shreg == $past(frame_of(result_i, fmt)))
        else $error("read after convert did not start");
    a_during_start: assert property (state == ST_IDLE && master && read_timing && conv_start_i
        |=> state == ST_MASTER && shreg == $past(frame_of(stored, fmt)))
        else $error("read during convert did not start");
    a_data_steady: assert property (clk_moves |-> $stable(shreg))
        else $error("data moved on a clock edge");
    a_slave_shift: assert property (state == ST_SLAVE && act_edge && !csn && slave && !rd_fail
        |=> shreg == {$past(shreg[FRAME_W-2:0]), $past(read_timing)})
        else $error("slave shift wrong");
    a_err_pulse: assert property (rd_fail |=> err_pulse)
        else $error("read error pulse wrong");
    a_wb_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus ack timing wrong");
endmodule // adc_serial_result_port

/* verilog/serial_port_defines.svh */
/*
 * Offsets, field positions, reset values and counts of the serial result port.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_DIVIDE 4'h0
`define OFS_STATUS 4'h4
`define OFS_RESULT 4'h8

// ****************************************
// Reset values and sizes
// ****************************************
`define DIVIDE_RESET 32'h0804_0201
`define RESULT_BITS 14
`define FRAME_BITS 16
`define SYNC_STAGES 3

// ****************************************
// Pin slots in the filtered pin vector
// ****************************************
`define PIN_SER 8
`define PIN_FMT 9
`define PIN_CSN 10
`define PIN_COUNT 11

`endif

/* verilog/serial_port_pkg.sv */
/*
 * Types shared by the serial result port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package serial_port_pkg;
    // Gray along idle -> shifting
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MASTER = 2'b01,
        ST_SLAVE = 2'b10
    } port_state_e;
endpackage
